// ===== hw/ddr2_col_map.svh
// Offsets, field positions, reset values and counts of the column-access block
// Assumes a 32-bit AHB-Lite slave decoding haddr[7:0]
`ifndef DDR2_COL_MAP_SVH
`define DDR2_COL_MAP_SVH
`define REG_MODE       8'h00
`define REG_EXT        8'h04
`define REG_STATUS     8'h08
`define REG_PEEK_ADDR  8'h0C
`define REG_PEEK_DATA  8'h10
`define MODE_BL_LSB    0
`define MODE_BT_BIT    3
`define MODE_CL_LSB    4
`define MODE_WR_LSB    9
`define EXT_AL_LSB     3
`define BL8_CODE       3'h3
`define MODE_RESET     32'h0000_0432
`define EXT_RESET      32'h0000_0000
`define ST_ILLEGAL_BIT 0
`define ST_EARLY_BIT   1
`define ST_RD_BIT      2
`define ST_WR_BIT      3
`define ST_BANKS_LSB   4
`define LINE_DEPTH     16
`define COL_GAP        5'h02
`define AGE_MAX        5'h1F
`endif

// ===== hw/ddr2_col_pkg.sv
// Types shared by the column-access block
// Assumes the constants of ddr2_col_map.svh
package ddr2_col_pkg;
   typedef enum logic [2:0] {CMD_NOP, CMD_READ, CMD_WRITE, CMD_PRECHARGE, CMD_OTHER} cmd_t;
   typedef enum logic [1:0] {RD_IDLE, RD_PREAMBLE, RD_DATA} rd_state_t;
   typedef struct packed {
      logic       valid;
      logic       wr;
      logic [1:0] bank;
      logic [2:0] col;
   } slot_t;
endpackage

// ===== hw/ddr2_pin_sync.sv
// Two-flop synchroniser for pins from outside the hclk domain
// Assumes one hclk domain; ce freezes both stages
`timescale 1ns/1ns
`default_nettype none
module ddr2_pin_sync
#(
   parameter int WIDTH = 37
)
(
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] synced
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] stable;
   } sync_t;

   sync_t st;
   sync_t next_st;

   // First stage feeds only the second
   always_comb
   begin
      next_st.meta   = pin;
      next_st.stable = st.meta;
   end

   // Register both stages
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         st <= '0;
      else if (ce)
         st <= next_st;
   end

   assign synced = st.stable;
endmodule // ddr2_pin_sync
`default_nettype wire

// ===== hw/ddr2_burst_column_access.sv
// Column-access burst logic of a four-bank 16-bit DDR2 memory
// Assumes an AHB-Lite master, and a controller driving the link pins slowly
//
// Behaviour
// [RULE1] Burst length 4 or 8 from mode bits [2:0]; order from bit 3
// [RULE2] Sequential eight-burst rotates inside its nibble, then the other nibble
// [RULE3] Interleaved eight-burst visits start XOR index 0 to 7
// [RULE4] Four-burst orders by two low bits only; third bit kept
// [RULE5] Controller never interrupts a four-burst
// [RULE6] An eight-read burst is interrupted only by a read
// [RULE7] An eight-write burst is interrupted only by a write
// [RULE8] Interrupting read comes exactly two clocks after the read
// [RULE9] Interrupting write comes exactly two clocks after the write
// [RULE10] An interrupting command may target any bank
// [RULE11] A burst with autoprecharge is never interrupted
// [RULE12] Interrupting command may itself carry autoprecharge
// [RULE13] Spacing uses the programmed length; read to precharge is AL plus BL/2
// [RULE14] Write recovery counts from the nominal uninterrupted burst end
// [RULE15] No burst stop; bursts end by completion or legal interruption
// [RULE16] First read word appears read latency clocks after the command
// [RULE17] Read strobe driven low one clock before the first word
// [RULE18] First read word on rising strobe, later words on each edge
// [RULE19] Write latency is read latency minus one
// [RULE20] Controller gives write preamble, then words on strobe edges
// [RULE21] Data after the programmed number of write words is ignored
// [RULE22] One mask per byte, sampled with write data, unused on reads
// [RULE23] Precharge closes all banks on high A10, else one bank by bits
// [RULE24] Column commands are at least two clocks apart
// [RULE25] A masked byte is left unchanged in the store
`timescale 1ns/1ns
`default_nettype none
`include "ddr2_col_map.svh"
module ddr2_burst_column_access
(
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        ce,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   input  wire logic        link_ck,
   input  wire logic        cs_n,
   input  wire logic        ras_n,
   input  wire logic        cas_n,
   input  wire logic        we_n,
   input  wire logic        bank_select_low,
   input  wire logic        bank_select_high,
   input  wire logic        autoprecharge_addr_bit,
   input  wire logic [9:0]  col_addr,
   input  wire logic [15:0] dq_in,
   output logic      [15:0] dq_out,
   output logic             dq_oe,
   input  wire logic        dqs_in,
   output logic             dqs_out,
   output logic             dqs_oe,
   input  wire logic [1:0]  write_byte_mask
);
   typedef struct packed {
      logic                                     ck_q;
      logic                                     dqs_q;
      ddr2_col_pkg::slot_t [`LINE_DEPTH-1:0]    line;
      logic [31:0]                              mode;
      logic [31:0]                              ext;
      logic                                     illegal;
      logic                                     early_pre;
      logic [3:0]                               pre_banks;
      logic [4:0]                               peek_addr;
      logic [31:0][15:0]                        mem;
      ddr2_col_pkg::rd_state_t                  rd_state;
      logic [1:0]                               rd_bank;
      logic [2:0]                               rd_start;
      logic [2:0]                               rd_idx;
      logic [2:0]                               rd_off;
      logic                                     wr_active;
      logic [1:0]                               wr_bank;
      logic [2:0]                               wr_start;
      logic [2:0]                               wr_idx;
      logic                                     col_wr;
      logic                                     col_ap;
      logic [4:0]                               since_col;
      logic [4:0]                               rd_age;
      logic [4:0]                               wr_age;
      logic                                     bus_wr;
      logic                                     bus_rd;
      logic [7:0]                               bus_addr;
      logic [31:0]                              hrdata;
      logic                                     hreadyout;
      logic                                     hresp;
      logic [15:0]                              dq_out;
      logic                                     dq_oe;
      logic                                     dqs_out;
      logic                                     dqs_oe;
   } state_t;

   state_t                                   st;
   state_t                                   n;
   logic [36:0]                              pins;
   logic [36:0]                              synced;
   logic                                     ck_s;
   logic                                     cs_s;
   logic                                     ras_s;
   logic                                     cas_s;
   logic                                     we_s;
   logic [1:0]                               ba_s;
   logic                                     ap_s;
   logic [9:0]                               col_s;
   logic                                     dqs_s;
   logic [1:0]                               mask_s;
   logic [15:0]                              dq_s;
   logic                                     ck_rise;
   logic                                     ck_fall;
   logic                                     dqs_edge;
   logic                                     bl8;
   logic                                     il;
   logic [3:0]                               rl;
   logic [3:0]                               wl;
   logic [2:0]                               last_idx;
   logic [4:0]                               half;
   logic [4:0]                               twr;
   ddr2_col_pkg::cmd_t                       cmd;
   ddr2_col_pkg::slot_t                      new_slot;
   ddr2_col_pkg::slot_t [`LINE_DEPTH-1:0]    shifted;
   logic                                     rd_go;
   logic                                     pre_go;
   logic                                     wr_go;
   logic                                     cap_we;
   logic [4:0]                               cap_addr;
   logic [1:0]                               cap_mask;
   logic [7:0]                               cap_byte0;

   ////////////////////////////////////////////////////////////////////////////
   // Helpers

   // Column offset of word idx of a burst
   function automatic logic [2:0] burst_col(input logic [2:0] start,
                                            input logic [2:0] idx,
                                            input logic       interleave);
      burst_col = interleave ? (start ^ idx)
                             : {start[2] ^ idx[2], 2'(start[1:0] + idx[1:0])};
   endfunction

   // Saturating age count
   function automatic logic [4:0] sat_inc(input logic [4:0] v);
      sat_inc = (v == `AGE_MAX) ? v : 5'(v + 5'h01);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisation and decode

   ddr2_pin_sync #(.WIDTH(37)) u_sync
   (
      .hclk    (hclk),
      .hresetn (hresetn),
      .ce      (ce),
      .pin     (pins),
      .synced  (synced)
   );

   // Pin bundle and its synchronised copy
   assign pins = {link_ck, cs_n, ras_n, cas_n, we_n, bank_select_high, bank_select_low,
                  autoprecharge_addr_bit, col_addr, dqs_in, write_byte_mask, dq_in};
   assign {ck_s, cs_s, ras_s, cas_s, we_s, ba_s, ap_s, col_s, dqs_s, mask_s, dq_s} = synced;

   // Edges and programmed timing
   assign ck_rise  = ck_s & ~st.ck_q;
   assign ck_fall  = ~ck_s & st.ck_q;
   assign dqs_edge = dqs_s ^ st.dqs_q;
   assign bl8      = st.mode[`MODE_BL_LSB +: 3] == `BL8_CODE;  // [RULE1]
   assign il       = st.mode[`MODE_BT_BIT];                     // [RULE1]
   assign rl       = 4'(st.ext[`EXT_AL_LSB +: 3]) + 4'(st.mode[`MODE_CL_LSB +: 3]); // [RULE16]
   assign wl       = rl - 4'h1;                                 // [RULE19]
   assign last_idx = bl8 ? 3'h7 : 3'h3;
   assign half     = bl8 ? 5'h04 : 5'h02;
   assign twr      = 5'(st.mode[`MODE_WR_LSB +: 3]);

   // Command decode from the strobes
   assign cmd = cs_s ? ddr2_col_pkg::CMD_NOP :
                ({ras_s, cas_s, we_s} == 3'h5) ? ddr2_col_pkg::CMD_READ :
                ({ras_s, cas_s, we_s} == 3'h4) ? ddr2_col_pkg::CMD_WRITE :
                ({ras_s, cas_s, we_s} == 3'h2) ? ddr2_col_pkg::CMD_PRECHARGE :
                ({ras_s, cas_s, we_s} == 3'h7) ? ddr2_col_pkg::CMD_NOP :
                ddr2_col_pkg::CMD_OTHER;

   // Latency line; each slot carries its own bank
   assign new_slot.valid = (cmd == ddr2_col_pkg::CMD_READ) || (cmd == ddr2_col_pkg::CMD_WRITE);
   assign new_slot.wr    = cmd == ddr2_col_pkg::CMD_WRITE;
   assign new_slot.bank  = ba_s;                                // [RULE10]
   assign new_slot.col   = col_s[2:0];
   assign shifted        = {st.line[`LINE_DEPTH-2:0], new_slot};
   assign rd_go          = shifted[rl].valid && !shifted[rl].wr;  // [RULE16]
   assign pre_go         = shifted[wl].valid && !shifted[wl].wr;  // [RULE17]
   assign wr_go          = shifted[wl].valid && shifted[wl].wr;   // [RULE19]

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      n         = st;
      cap_we    = 1'b0;
      cap_addr  = 5'h00;
      cap_mask  = 2'h0;
      cap_byte0 = 8'h00;
      // Bus data phase of a write; status flags clear by writing one
      if (st.bus_wr)
      begin
         unique case (st.bus_addr)
            `REG_MODE:      n.mode = hwdata;
            `REG_EXT:       n.ext = hwdata;
            `REG_STATUS:
            begin
               n.illegal   = st.illegal & ~hwdata[`ST_ILLEGAL_BIT];
               n.early_pre = st.early_pre & ~hwdata[`ST_EARLY_BIT];
            end
            `REG_PEEK_ADDR: n.peek_addr = hwdata[4:0];
            default:        n.bus_wr = 1'b0;
         endcase
         n.bus_wr = 1'b0;
      end
      // Bus read answer after one wait cycle
      if (st.bus_rd)
      begin
         unique case (st.bus_addr)
            `REG_MODE:      n.hrdata = st.mode;
            `REG_EXT:       n.hrdata = st.ext;
            `REG_STATUS:    n.hrdata = {24'h000000, st.pre_banks, st.wr_active,
                                        st.rd_state != ddr2_col_pkg::RD_IDLE,
                                        st.early_pre, st.illegal};
            `REG_PEEK_ADDR: n.hrdata = {27'h0000000, st.peek_addr};
            `REG_PEEK_DATA: n.hrdata = {16'h0000, st.mem[st.peek_addr]};
            default:        n.hrdata = 32'h00000000;
         endcase
         n.bus_rd    = 1'b0;
         n.hreadyout = 1'b1;
      end
      // Bus address phase
      if (hsel && htrans[1] && hready)
      begin
         n.bus_addr  = haddr[7:0];
         n.bus_wr    = hwrite && (hsize == 3'h2);
         n.bus_rd    = !hwrite;
         n.hreadyout = hwrite;
      end
      n.ck_q  = ck_s;
      n.dqs_q = dqs_s;
      // Link rising edge: commands, checks, burst starts
      if (ck_rise)
      begin
         n.line      = shifted;
         n.since_col = sat_inc(st.since_col);
         n.rd_age    = sat_inc(st.rd_age);
         n.wr_age    = sat_inc(st.wr_age);
         if (new_slot.valid)
         begin
            // Interruption inside the programmed burst must be legal
            if (n.since_col < half && (!bl8 || st.col_ap || n.since_col != `COL_GAP
                || st.col_wr != new_slot.wr))  // [RULE5] [RULE6] [RULE7] [RULE8] [RULE9] [RULE11]
               n.illegal = 1'b1;
            if (n.since_col < `COL_GAP)    // [RULE24]
               n.illegal = 1'b1;
            n.since_col = 5'h00;
            n.col_wr    = new_slot.wr;
            n.col_ap    = ap_s;            // [RULE12]
            if (new_slot.wr)
               n.wr_age = 5'h00;
            else
               n.rd_age = 5'h00;
         end
         if (cmd == ddr2_col_pkg::CMD_PRECHARGE)
         begin
            n.pre_banks = ap_s ? 4'hF : 4'(4'h1 << ba_s);  // [RULE23]
            // Spacing from the last column command at programmed length
            if (st.col_wr ? (n.since_col < 5'(wl) + half + twr)      // [RULE14]
                          : (n.since_col < 5'(st.ext[`EXT_AL_LSB +: 3]) + half)) // [RULE13]
               n.early_pre = 1'b1;
            if (n.since_col < half)         // [RULE6] [RULE7]
               n.illegal = 1'b1;
         end
         // Read data path on the rising edge
         if (rd_go)
         begin
            n.rd_state = ddr2_col_pkg::RD_DATA;   // [RULE16]
            n.rd_start = shifted[rl].col;
            n.rd_bank  = shifted[rl].bank;        // [RULE10]
            n.rd_idx   = 3'h0;
            n.dqs_out  = 1'b1;                    // [RULE18]
         end
         else
         begin
            unique case (st.rd_state)
               ddr2_col_pkg::RD_IDLE:
               begin
                  if (pre_go)
                     n.rd_state = ddr2_col_pkg::RD_PREAMBLE;  // [RULE17]
                  n.dqs_out = 1'b0;
               end
               ddr2_col_pkg::RD_PREAMBLE:
               begin
                  n.rd_state = ddr2_col_pkg::RD_IDLE;
                  n.dqs_out  = 1'b0;
               end
               ddr2_col_pkg::RD_DATA:
               begin
                  // Burst runs to its programmed end
                  if (st.rd_idx == last_idx)   // [RULE15]
                  begin
                     n.rd_state = pre_go ? ddr2_col_pkg::RD_PREAMBLE : ddr2_col_pkg::RD_IDLE;
                     n.dqs_out  = 1'b0;
                  end
                  else
                  begin
                     n.rd_idx  = 3'(st.rd_idx + 3'h1);
                     n.dqs_out = 1'b1;
                  end
               end
            endcase
         end
         // Write burst arms at write latency; a new write restarts it
         if (wr_go)
         begin
            n.wr_active = 1'b1;            // [RULE19]
            n.wr_start  = shifted[wl].col;
            n.wr_bank   = shifted[wl].bank;
            n.wr_idx    = 3'h0;
         end
      end
      // Read data path on the falling edge
      if (ck_fall && st.rd_state == ddr2_col_pkg::RD_DATA)
      begin
         n.rd_idx  = 3'(st.rd_idx + 3'h1);  // [RULE18]
         n.dqs_out = 1'b0;
      end
      // Write capture on each strobe edge of an armed burst
      if (n.wr_active && dqs_edge)
      begin
         cap_we    = 1'b1;
         cap_addr  = {n.wr_bank, burst_col(n.wr_start, n.wr_idx, il)};  // [RULE2] [RULE3] [RULE4]
         cap_mask  = mask_s;                                           // [RULE22]
         cap_byte0 = st.mem[cap_addr][7:0];
         for (int b = 0; b < 2; b++)
         begin
            if (!mask_s[b])
               n.mem[cap_addr][8*b +: 8] = dq_s[8*b +: 8];             // [RULE25]
         end
         if (n.wr_idx == last_idx)
            n.wr_active = 1'b0;            // [RULE21]
         else
            n.wr_idx = 3'(n.wr_idx + 3'h1);
      end
      // Registered pin drive
      n.rd_off = burst_col(n.rd_start, n.rd_idx, il);  // [RULE2] [RULE3] [RULE4]
      n.dq_out = n.mem[{n.rd_bank, n.rd_off}];
      n.dq_oe  = n.rd_state == ddr2_col_pkg::RD_DATA;
      n.dqs_oe = n.rd_state != ddr2_col_pkg::RD_IDLE;
      n.hresp  = 1'b0;
   end

   // State register; ce freezes everything
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st           <= '0;
         st.mode      <= `MODE_RESET;
         st.ext       <= `EXT_RESET;
         st.since_col <= `AGE_MAX;
         st.rd_age    <= `AGE_MAX;
         st.wr_age    <= `AGE_MAX;
         st.hreadyout <= 1'b1;
      end
      else if (ce)
         st <= n;
   end

   // Outputs straight from the state
   assign hrdata    = st.hrdata;
   assign hreadyout = st.hreadyout;
   assign hresp     = st.hresp;
   assign dq_out    = st.dq_out;
   assign dq_oe     = st.dq_oe;
   assign dqs_out   = st.dqs_out;
   assign dqs_oe    = st.dqs_oe;

   ////////////////////////////////////////////////////////////////////////////
   // Checks

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   sequence s_read_starts;
      $rose(st.dq_oe);
   endsequence

   sequence s_pre_all;
      ck_rise && ce && cmd == ddr2_col_pkg::CMD_PRECHARGE && ap_s;
   endsequence

   AST_PREAMBLE: assert property ( // [RULE17]
      s_read_starts |-> $past(st.dqs_oe) && !$past(st.dqs_out))
      else $error("read data without strobe preamble");

   AST_FIRST_RISE: assert property ( // [RULE18]
      s_read_starts |-> st.dqs_out)
      else $error("first read word not on rising strobe");

   AST_RL: assert property ( // [RULE16]
      s_read_starts |-> st.rd_age == 5'(rl))
      else $error("read data not at read latency");

   AST_WL: assert property ( // [RULE19]
      $rose(st.wr_active) |-> st.wr_age == 5'(wl))
      else $error("write capture not armed at write latency");

   AST_STOP: assert property ( // [RULE21]
      $fell(st.wr_active) |-> $past(st.wr_idx) == last_idx)
      else $error("write capture stopped at wrong word count");

   AST_SEQ_ORDER: assert property ( // [RULE2] [RULE4]
      st.dq_oe && !il |-> st.rd_off[1:0] == 2'(st.rd_start[1:0] + st.rd_idx[1:0])
                          && st.rd_off[2] == (st.rd_start[2] ^ (bl8 & st.rd_idx[2])))
      else $error("sequential burst order wrong");

   AST_IL_ORDER: assert property ( // [RULE3]
      st.dq_oe && il |-> st.rd_off == (st.rd_start ^ st.rd_idx) && (bl8 || !st.rd_idx[2]))
      else $error("interleaved burst order wrong");

   AST_BURST_HOLD: assert property ( // [RULE15]
      s_read_starts |-> st.dq_oe [*8])
      else $error("read burst ended early");

   AST_PRE_ALL: assert property ( // [RULE23]
      s_pre_all |=> st.pre_banks == 4'hF)
      else $error("precharge all did not select every bank");

   AST_MASK: assert property ( // [RULE25]
      cap_we && ce && cap_mask[0] |=> st.mem[$past(cap_addr)][7:0] == $past(cap_byte0))
      else $error("masked low byte was changed");
endmodule // ddr2_burst_column_access
`default_nettype wire

// ===== sim/ddr2_ctrl_model.sv
// Controller model: link clock, commands, write data, masks and strobes
// Assumes the bench resolves the shared data and strobe wires
`timescale 1ns/1ns
`default_nettype none
module ddr2_ctrl_model
(
   output logic        ck,
   output logic [3:0]  cmd_n,
   output logic [2:0]  bap,
   output logic [9:0]  col,
   output logic [15:0] dq_m,
   output logic [1:0]  dm,
   output logic        dq_en,
   output logic        dqs_m,
   output logic        dqs_en
);
   ////////////////////////////////////////
   // Idle pins, then a free running 400 ns link clock
   initial
   begin
      ck = 1'b0;
      cmd_n = 4'hF;
      bap = 3'h0;
      col = 10'h000;
      dq_m = 16'h0000;
      dm = 2'h0;
      dq_en = 1'b0;
      dqs_m = 1'b0;
      dqs_en = 1'b0;
   end
   always #200 ck = ~ck;
   // One command around a rise, NOP after; back-to-back calls put commands two clocks apart
   task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [2:0] a);
      @(negedge ck);
      cmd_n = c;
      bap = b;
      col = {7'h00, a};
      @(negedge ck);
      cmd_n = 4'h7;
   endtask
   // Preamble half a clock early, then a word and mask per strobe edge, two spare
   task automatic wr(input int wl, input int n, input logic [15:0] w[10], input logic [1:0] m[10]);
      repeat (wl - 1) @(negedge ck);
      dq_en = 1'b1;
      dqs_en = 1'b1;
      for (int i = 0; i < n + 2; i++)
      begin
         @(ck);
         #50 dq_m = w[i];
         dm = m[i];
         #100 dqs_m = ~dqs_m;
      end
      @(ck);
      #150 dq_en = 1'b0;
      dqs_en = 1'b0;
   endtask
endmodule // ddr2_ctrl_model
`default_nettype wire

// ===== sim/ddr2_burst_column_access_bench.sv
// Bench of the column-access block: register bus here, controller model on the link
// Assumes the model owns the link clock; undriven strobe is pulled low
`timescale 1ns/1ns
`default_nettype none
`include "ddr2_col_map.svh"
module ddr2_burst_column_access_bench;
   logic        hclk = 1'b0, hresetn = 1'b0, hwrite = 1'b0, hreadyout, ck, dq_en;
   logic        dqs_m, dqs_en, dq_oe, dqs_out, dqs_oe, dqs_w, hresp;
   logic [1:0]  htrans = 2'h0, dm;
   logic [2:0]  bap;
   logic [9:0]  col;
   logic [15:0] dq_m, dq_out, dq_w, mem[32], rq[$];
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
   int          num_errors = 0, n_checks = 0, pre_cnt = 0;
   ////////////////////////////////////////
   always #25 hclk = ~hclk;
   assign dq_w = dq_en ? dq_m : dq_oe ? dq_out : {16{hclk}};
   assign dqs_w = dqs_en ? dqs_m : dqs_oe & dqs_out;
   logic [3:0]  cmd_n_w;
   ddr2_ctrl_model mdl (.ck(ck), .cmd_n(cmd_n_w), .bap(bap), .col(col), .dq_m(dq_m), .dm(dm),
      .dq_en(dq_en), .dqs_m(dqs_m), .dqs_en(dqs_en));
   ddr2_burst_column_access DUT
   (
      .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .link_ck(ck), .cs_n(cmd_n_w[3]), .ras_n(cmd_n_w[2]),
      .cas_n(cmd_n_w[1]), .we_n(cmd_n_w[0]), .bank_select_low(bap[0]),
      .bank_select_high(bap[1]), .autoprecharge_addr_bit(bap[2]), .col_addr(col),
      .dq_in(dq_w), .dq_out(dq_out), .dq_oe(dq_oe), .dqs_in(dqs_w), .dqs_out(dqs_out),
      .dqs_oe(dqs_oe), .write_byte_mask(dm)
   );
   ////////////////////////////////////////
   // Expected column of word i from the start column, length and order
   function automatic logic [2:0] ord(input logic [2:0] s, input logic [2:0] i, input logic b8,
      input logic il);
      logic [2:0] k;
      k = b8 ? i : {1'b0, i[1:0]};
      ord = il ? s ^ k : {s[2] ^ k[2], s[1:0] + k[1:0]};
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("BAD %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // Bounded wait for hready at a rising edge
   task automatic wait_rdy();
      int k = 0;
      do
      begin
         @(posedge hclk);
         k++;
      end
      while (hreadyout !== 1'b1 && k < 40);
      if (k >= 40)
      begin
         num_errors++;
         close_out();
      end
   endtask
   // One single word transfer: address phase, then data phase
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
      @(posedge hclk);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
      q = hrdata;
   endtask
   ////////////////////////////////////////
   // Count preamble cycles; take each read word just after its strobe edge
   always @(posedge hclk)
      pre_cnt <= (dqs_oe && !dq_oe && !dqs_out) ? pre_cnt + 1 : 0;
   always @(dqs_out)
   begin
      #1;
      if (dq_oe && rq.size() == 0)
         check(pre_cnt inside {[7:9]}, 1'b1);
      if (dq_oe)
         rq.push_back(dq_out);
   end
   initial
   begin
      static logic [31:0] modes[4] = '{32'h0000_0432, 32'h0000_043A, 32'h0000_0433, 32'h0000_043B};
      logic [15:0] w[10];
      logic [1:0]  m[10];
      logic [2:0]  s, k;
      logic [1:0]  b;
      int          bl, n;
      void'($urandom(43320));
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, `REG_MODE, 32'h0, r);
      check(r, `MODE_RESET);
      ahb(1'b0, `REG_EXT, 32'h0, r);
      check(r, `EXT_RESET);
      ahb(1'b0, 8'h40, 32'h0, r);
      check(r, 32'h0);
      // Every length and order: plain write, masked write with spare words, read back
      foreach (modes[j])
      begin
         ahb(1'b1, `REG_MODE, modes[j], r);
         bl = modes[j][2:0] == `BL8_CODE ? 8 : 4;
         b = 2'($urandom);
         s = 3'($urandom);
         for (int p = 0; p < 2; p++)
         begin
            foreach (w[i])
            begin
               w[i] = 16'($urandom);
               m[i] = p ? 2'($urandom) : 2'h0;
            end
            mdl.cmd(4'h4, {1'b0, b}, s);
            mdl.wr(2, bl, w, m);
            for (int i = 0; i < bl; i++)
            begin
               k = ord(s, 3'(i), bl == 8, modes[j][3]);
               if (!m[i][0]) mem[{b, k}][7:0] = w[i][7:0];
               if (!m[i][1]) mem[{b, k}][15:8] = w[i][15:8];
            end
         end
         rq.delete();
         mdl.cmd(4'h5, {1'b0, b}, s);
         n = 0;
         do
         begin
            @(posedge ck);
            n++;
            #200;
         end
         while (!dq_oe && n < 20);
         check(n, 3);
         repeat (bl / 2 + 2) @(posedge ck);
         check(rq.size(), bl);
         foreach (rq[i]) check(rq[i], mem[{b, ord(s, 3'(i), bl == 8, modes[j][3])}]);
      end
      // Precharge each bank, then all banks
      repeat (8) @(posedge ck);
      for (int i = 0; i < 5; i++)
      begin
         mdl.cmd(4'h2, 3'(i), 3'h0);
         repeat (3) @(posedge ck);
         ahb(1'b0, `REG_STATUS, 32'h0, r);
         check(r[7:4], i == 4 ? 4'hF : 4'h1 << i);
      end
      check({hresp, r[1:0]}, 3'h0);
      // Eight-write cut by a read two clocks later is flagged, then cleared
      mdl.cmd(4'h4, 3'h0, 3'h0);
      mdl.cmd(4'h5, 3'h0, 3'h0);
      ahb(1'b0, `REG_STATUS, 32'h0, r);
      check(r[0], 1'b1);
      ahb(1'b1, `REG_STATUS, 32'h1, r);
      ahb(1'b0, `REG_STATUS, 32'h0, r);
      check(r[0], 1'b0);
      close_out();
   end
endmodule // ddr2_burst_column_access_bench
`default_nettype wire
